// ### src/bdg_top.sv
// bdg_top: bus ownership, strobes, buffer direction, memory map, waits
// and port decode of an 8-bit processor board
// assumes processor strobes synchronous to clk; dram acknowledges,
// modem and serial-memory inputs asynchronous
`timescale 1ns/1ps
`default_nettype none
module bdg_top #(
	parameter int WAIT_DELAY = bdg_pkg::WAIT_CYCLES
) (
	input  wire logic                           clk,
	input  wire logic                           arst_n,
	input  wire logic [bdg_pkg::BYTE_W-1:0]     cpu_addr_hi,
	input  wire logic [bdg_pkg::BYTE_W-1:0]     bus_addr_lo,
	input  wire logic                           cpu_m1_n,
	input  wire logic                           cpu_iorq_n,
	input  wire logic                           cpu_mreq_n,
	input  wire logic                           cpu_rd_n,
	input  wire logic                           cpu_wr_n,
	input  wire logic                           bus_grant_from_cpu_n,
	input  wire logic                           dma_owns_bus,
	input  wire logic [bdg_pkg::BYTE_W-1:0]     dma_addr_hi,
	input  wire logic                           dma_port_read_n,
	input  wire logic                           dma_port_write_n,
	input  wire logic                           dma_mem_read_n,
	input  wire logic                           dma_mem_write_n,
	input  wire logic [3:0]                     dma_channel_grant_n,
	input  wire logic                           ext_vector_strap,
	input  wire logic                           dram_early_grant_n,
	input  wire logic                           dram_data_valid_n,
	input  wire logic [1:0]                     modem_ring_n,
	input  wire logic [1:0]                     modem_ready_n,
	input  wire logic                           smem_data_in,
	input  wire logic [bdg_pkg::BYTE_W-1:0]     internal_data_lines_in,
	output logic      [bdg_pkg::BYTE_W-1:0]     internal_data_lines_out,
	output logic                                internal_data_lines_oe,
	output logic      [bdg_pkg::BYTE_W-1:0]     addr_hi,
	output logic                                port_read_strobe_n,
	output logic                                port_write_strobe_n,
	output logic                                mem_read_strobe_n,
	output logic                                mem_write_strobe_n,
	output logic                                data_buf_inward,
	output logic                                rom_cs_n,
	output logic                                ram_cs_n,
	output logic                                cpu_wait_n,
	output logic                                dma_ready,
	output logic      [bdg_pkg::IO_BLOCKS-1:0]  io_block_sel_n,
	output logic                                offboard_port_flag,
	output logic      [bdg_pkg::BYTE_W-1:0]     smem_ctrl
);
	import bdg_pkg::*;

	typedef struct packed {
		logic [1:0]        rst_pipe;
		bdg_map_t          map;
		logic [BYTE_W-1:0] smem;
		logic [BYTE_W-1:0] rd_data;
		logic              rd_oe;
	} bdg_top_state_t;

	bdg_top_state_t    s;
	bdg_top_state_t    next_s;
	logic              rst_n;
	logic [SYNC_W-1:0] sync_out;
	logic [3:0]        ring_ready;
	logic              grant_s_n;
	logic              valid_s_n;
	logic              smem_data_s;
	logic              cpu_master;
	logic              dma_master;
	logic              cpu_prd;
	logic              cpu_pwr;
	logic              cpu_mrd;
	logic              cpu_mwr;
	logic              io_en;
	logic              intack;
	logic              ext_port;
	logic              chan_ext;
	logic              rom_region;
	logic              map_wr;
	logic              modem_rd;
	logic              smem_sel;
	logic [4:0]        top5;

	bdg_wait_if wif ();

	// ----------------------------------------
	// reset release and input synchronisers
	// ----------------------------------------
	assign rst_n = s.rst_pipe[1];

	bdg_sync #(
		.W    (SYNC_W)
	) u_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.din  ({smem_data_in, dram_data_valid_n, dram_early_grant_n,
			modem_ready_n, modem_ring_n}),
		.dout (sync_out)
	);

	assign ring_ready  = sync_out[3:0];
	assign grant_s_n   = sync_out[4];
	assign valid_s_n   = sync_out[5];
	assign smem_data_s = sync_out[6];

	// ----------------------------------------
	// bus ownership and address mux
	// ----------------------------------------
	// the processor floats its bus after the cycle and grants it;
	// the dma only drives after that grant, so the grant selects
	assign cpu_master = bus_grant_from_cpu_n;
	assign dma_master = !bus_grant_from_cpu_n;
	assign addr_hi    = dma_master ? dma_addr_hi : cpu_addr_hi;

	// ----------------------------------------
	// strobes
	// ----------------------------------------
	assign cpu_prd = !cpu_iorq_n && !cpu_rd_n && cpu_m1_n;
	assign cpu_pwr = !cpu_iorq_n && !cpu_wr_n && cpu_m1_n;
	assign cpu_mrd = !cpu_mreq_n && !cpu_rd_n;
	assign cpu_mwr = !cpu_mreq_n && !cpu_wr_n;

	assign port_read_strobe_n  = cpu_master ? !cpu_prd : dma_port_read_n;
	// dma write to a port only once memory data is valid
	assign port_write_strobe_n = cpu_master ? !cpu_pwr :
		(dma_port_write_n || !wif.dma_ready);
	assign mem_read_strobe_n   = cpu_master ? !cpu_mrd : dma_mem_read_n;
	assign mem_write_strobe_n  = cpu_master ? !cpu_mwr : dma_mem_write_n;

	// ----------------------------------------
	// port decode
	// ----------------------------------------
	assign io_en = cpu_master && !dma_owns_bus;

	always_comb
	begin
		io_block_sel_n = '1;
		if (io_en && bus_addr_lo[7:6] == 2'b00)
			io_block_sel_n = ~(16'h0001 << bus_addr_lo[5:2]);
	end

	always_comb
	begin
		if (bus_addr_lo[7:6] == 2'b00)
			ext_port = !LOCAL_BLOCKS[bus_addr_lo[5:2]];
		else
			ext_port = bus_addr_lo[7:4] != PORT_DMA_HI;
	end

	assign offboard_port_flag = io_en && ext_port;

	// selected devices qualify their block with the io request
	assign map_wr   = io_en && cpu_pwr &&
		bus_addr_lo[7:2] == PORT_MAP_ROM56[7:2];
	assign modem_rd = io_en && cpu_prd && bus_addr_lo == PORT_MODEM;
	assign smem_sel = io_en && !cpu_iorq_n && cpu_m1_n &&
		bus_addr_lo[7:2] == PORT_SMEM[7:2];

	// ----------------------------------------
	// data buffer direction
	// ----------------------------------------
	assign intack   = cpu_master && !cpu_m1_n && !cpu_iorq_n;
	assign chan_ext = !dma_channel_grant_n[0] || !dma_channel_grant_n[1] ||
		!dma_channel_grant_n[3];
	// outward unless one of the inward cases holds
	assign data_buf_inward = (intack && ext_vector_strap) ||
		(!port_read_strobe_n && (chan_ext || offboard_port_flag));

	// ----------------------------------------
	// memory map
	// ----------------------------------------
	assign top5 = addr_hi[7:3];

	always_comb
	begin
		unique case (s.map)
			MAP_ROM56:
				rom_region = top5 < ROM56_TOP;
			MAP_ROM16:
				rom_region = top5 < ROM16_TOP;
			MAP_RAM:
				rom_region = 1'b0;
			default:
				rom_region = 1'b0;
		endcase
	end

	// reads only; dma always sees ram; writes always land in ram
	assign rom_cs_n = !(!mem_read_strobe_n && cpu_master && !dma_owns_bus &&
		rom_region);
	assign ram_cs_n = !((!mem_read_strobe_n || !mem_write_strobe_n) &&
		rom_cs_n);

	// ----------------------------------------
	// wait states
	// ----------------------------------------
	assign wif.cpu_mem_access = cpu_master && !cpu_mreq_n &&
		(!cpu_rd_n || !cpu_wr_n);
	assign wif.dma_mem_read   = dma_master && !dma_mem_read_n;
	assign wif.early_grant    = !grant_s_n;
	assign wif.data_valid     = !valid_s_n;

	bdg_wait_gen #(
		.DELAY_CYCLES(WAIT_DELAY)
	) u_wait (
		.clk  (clk),
		.rst_n(rst_n),
		.wif  (wif)
	);

	assign cpu_wait_n = wif.cpu_wait_n;
	assign dma_ready  = wif.dma_ready;

	// ----------------------------------------
	// state update
	// ----------------------------------------
	always_comb
	begin
		next_s          = s;
		next_s.rst_pipe = {s.rst_pipe[0], 1'b1};
		next_s.rd_oe    = modem_rd || (smem_sel && cpu_prd);
		next_s.rd_data  = RD_RESET;
		if (map_wr)
		begin
			// data is ignored, the address alone picks the map
			unique case (bus_addr_lo)
				PORT_MAP_ROM56:
					next_s.map = MAP_ROM56;
				PORT_MAP_ROM16:
					next_s.map = MAP_ROM16;
				PORT_MAP_OFF_A, PORT_MAP_OFF_B:
					next_s.map = MAP_RAM;
				default:
					next_s.map = s.map;
			endcase
		end
		if (smem_sel && cpu_pwr)
			next_s.smem = internal_data_lines_in;
		if (modem_rd)
			next_s.rd_data = {4'h0, ring_ready};
		else if (smem_sel && cpu_prd)
			next_s.rd_data = {smem_data_s, s.smem[6:0]};
		if (!rst_n)
		begin
			next_s.map     = MAP_RESET;
			next_s.smem    = SMEM_RESET;
			next_s.rd_data = RD_RESET;
			next_s.rd_oe   = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			s <= '{rst_pipe: 2'h0, map: MAP_RESET, smem: SMEM_RESET,
				rd_data: RD_RESET, rd_oe: 1'b0};
		else
			s <= next_s;
	end

	assign internal_data_lines_out = s.rd_data;
	assign internal_data_lines_oe  = s.rd_oe;
	assign smem_ctrl               = s.smem;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	addr_mux_a: assert property (dma_master |-> addr_hi == dma_addr_hi)
		else $error("upper address not from dma latch");
	strobe_pass_a: assert property (dma_master |->
		mem_read_strobe_n == dma_mem_read_n && mem_write_strobe_n == dma_mem_write_n)
		else $error("dma memory strobes not passed");
	buf_out_a: assert property ((!intack && port_read_strobe_n) |->
		!data_buf_inward)
		else $error("buffer inward without cause");
	buf_vector_a: assert property ((intack && ext_vector_strap) |->
		data_buf_inward)
		else $error("buffer outward on external vector");
	buf_read_a: assert property ((!port_read_strobe_n && chan_ext) |->
		data_buf_inward)
		else $error("buffer outward on dma channel read");
	write_ram_a: assert property (!mem_write_strobe_n |->
		!ram_cs_n && rom_cs_n)
		else $error("memory write not to ram");
	dma_ram_a: assert property ((dma_owns_bus && !mem_read_strobe_n) |->
		!ram_cs_n)
		else $error("dma access selected rom");
	map_low16_a: assert property ((map_wr && bus_addr_lo == PORT_MAP_ROM16)
		|=> s.map == MAP_ROM16)
		else $error("map not switched to 16k rom");
	map_off_a: assert property ((map_wr && bus_addr_lo[0])
		|=> s.map == MAP_RAM)
		else $error("map not switched to all ram");
	rom_decode_a: assert property ((s.map == MAP_ROM56 && cpu_master &&
		!dma_owns_bus && !mem_read_strobe_n) |-> (rom_cs_n == (top5 >= ROM56_TOP)))
		else $error("reset map decode wrong");
	dma_ports_a: assert property (dma_owns_bus |->
		&io_block_sel_n && !offboard_port_flag)
		else $error("port decode active under dma");
	modem_read_a: assert property (modem_rd |=>
		internal_data_lines_oe && internal_data_lines_out[3:0] == $past(ring_ready))
		else $error("modem inputs not returned");
	ext_flag_a: assert property ((io_en && bus_addr_lo[7:3] == 5'h02) |->
		offboard_port_flag)
		else $error("unallocated port not flagged");

	map_switch_c: cover property (map_wr ##1 s.map == MAP_ROM16);
	ext_read_c: cover property (data_buf_inward && offboard_port_flag);
	rom_read_c: cover property (!rom_cs_n);
endmodule
`default_nettype wire

// ### include/bdg_pkg.sv
// bdg_pkg: constants and types of the board bus decode glue
// assumes a 100 MHz processor-side clock
`default_nettype none
package bdg_pkg;
	localparam int          BYTE_W        = 8;
	localparam int          IO_BLOCKS     = 16;
	localparam int          SYNC_W        = 7;
	// port addresses
	localparam logic [7:0]  PORT_MAP_ROM56 = 8'h18;
	localparam logic [7:0]  PORT_MAP_OFF_A = 8'h19;
	localparam logic [7:0]  PORT_MAP_ROM16 = 8'h1A;
	localparam logic [7:0]  PORT_MAP_OFF_B = 8'h1B;
	localparam logic [7:0]  PORT_MODEM     = 8'h1C;
	localparam logic [7:0]  PORT_SMEM      = 8'h28;
	localparam logic [3:0]  PORT_DMA_HI    = 4'hF;
	// on-board port blocks of four within 00..3F
	localparam logic [15:0] LOCAL_BLOCKS   = 16'h34CC;
	// rom region limits on the top five address bits
	localparam logic [4:0]  ROM56_TOP      = 5'h1C;
	localparam logic [4:0]  ROM16_TOP      = 5'h08;
	// reset values
	localparam logic [7:0]  SMEM_RESET     = 8'h00;
	localparam logic [7:0]  RD_RESET       = 8'h00;
	// wait release delay
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          WAIT_DELAY_NS  = 50;
	localparam int          WAIT_CYCLES    =
		(WAIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {MAP_ROM56, MAP_ROM16, MAP_RAM} bdg_map_t;
	localparam bdg_map_t    MAP_RESET      = MAP_ROM56;
endpackage
`default_nettype wire

// ### include/bdg_wait_if.sv
// bdg_wait_if: request and answer between decode and wait generator
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface bdg_wait_if;
	logic cpu_mem_access;
	logic dma_mem_read;
	logic early_grant;
	logic data_valid;
	logic cpu_wait_n;
	logic dma_ready;

	modport ctrl (
		output cpu_mem_access,
		output dma_mem_read,
		output early_grant,
		output data_valid,
		input  cpu_wait_n,
		input  dma_ready
	);
	modport gen (
		input  cpu_mem_access,
		input  dma_mem_read,
		input  early_grant,
		input  data_valid,
		output cpu_wait_n,
		output dma_ready
	);
endinterface
`default_nettype wire

// ### src/bdg_sync.sv
// bdg_sync: three-stage input synchroniser with agreement filter
// assumes asynchronous inputs and a synchronised reset
`timescale 1ns/1ps
`default_nettype none
module bdg_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} bdg_sync_state_t;

	bdg_sync_state_t s;
	bdg_sync_state_t next_s;

	always_comb
	begin
		next_s    = s;
		next_s.s1 = din;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		// take a bit once the second and third stage agree
		for (int i = 0; i < W; i++)
		begin
			if (s.s2[i] == s.s3[i])
				next_s.q[i] = s.s3[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign dout = s.q;
endmodule
`default_nettype wire

// ### src/bdg_wait_gen.sv
// bdg_wait_gen: processor and dma wait states against dram acknowledges
// assumes synchronised acknowledges, active high, from the decode
`timescale 1ns/1ps
`default_nettype none
module bdg_wait_gen
	import bdg_pkg::*;
#(
	parameter int DELAY_CYCLES = bdg_pkg::WAIT_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst_n,
	bdg_wait_if.gen   wif
);
	typedef enum {W_IDLE, W_ARM, W_GRANT, W_DELAY, W_RELEASE} bdg_wst_t;
	typedef struct packed {
		bdg_wst_t   st;
		logic [3:0] cnt;
		logic       data_ok;
	} bdg_wait_state_t;

	bdg_wait_state_t s;
	bdg_wait_state_t next_s;
	logic            acc;

	assign acc = wif.cpu_mem_access;

	// ----------------------------------------
	// wait sequence
	// ----------------------------------------
	always_comb
	begin
		next_s = s;
		unique case (s.st)
			W_IDLE:
				if (acc)
					next_s.st = W_ARM;
			W_ARM:
				if (!acc)
					next_s.st = W_IDLE;
				else if (!wif.early_grant)
					next_s.st = W_GRANT;
			W_GRANT:
				if (!acc)
					next_s.st = W_IDLE;
				else if (wif.early_grant)
				begin
					next_s.st  = W_DELAY;
					next_s.cnt = 4'(DELAY_CYCLES - 1);
				end
			W_DELAY:
				if (!acc)
					next_s.st = W_IDLE;
				else if (s.cnt == 4'h0)
					next_s.st = W_RELEASE;
				else
					next_s.cnt = s.cnt - 4'h1;
			W_RELEASE:
				if (!acc)
					next_s.st = W_IDLE;
		endcase
		// dma data valid latch
		next_s.data_ok = wif.dma_mem_read & (s.data_ok | wif.data_valid);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '{st: W_IDLE, cnt: 4'h0, data_ok: 1'b0};
		else
			s <= next_s;
	end

	assign wif.cpu_wait_n = !(acc && s.st != W_RELEASE);
	assign wif.dma_ready  = !wif.dma_mem_read || s.data_ok;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	wait_first_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(acc) |-> !wif.cpu_wait_n)
		else $error("no wait state at start of memory access");
	wait_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(s.st == W_GRANT && wif.early_grant && acc) |=> (!wif.cpu_wait_n || !acc))
		else $error("wait released without delay");
	wait_release_a: assert property (@(posedge clk) disable iff (!rst_n)
		(s.st == W_DELAY && s.cnt == 4'h0 && acc) |=> (wif.cpu_wait_n || !acc))
		else $error("wait not released after delay");
	dma_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
		($rose(wif.dma_mem_read) && !s.data_ok) |-> !wif.dma_ready)
		else $error("dma ready before memory data valid");
	wait_done_c: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(wif.cpu_wait_n) && acc);
	dma_valid_c: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(wif.dma_ready) && wif.dma_mem_read);
endmodule
`default_nettype wire

// ### test/bdg_dram_model.sv
// bdg_dram_model: dram controller acknowledges seen by the glue block
// assumes low memory strobes from the glue and the bench clock
`timescale 1ns/1ps
`default_nettype none
module bdg_dram_model (
	input  wire logic clk,
	input  wire logic mem_rd_n,
	input  wire logic mem_wr_n,
	input  wire logic slow,
	output logic      early_grant_n,
	output logic      data_valid_n
);
	int cnt;
	initial
	begin
		early_grant_n = 1'b0;
		data_valid_n  = 1'b1;
		cnt           = 0;
	end
	// grant withdrawn when a request starts, back six clocks into the cycle (thirteen when slow)
	// slow mode stands for a refresh in the way
	// data valid later in the cycle, gone with the strobe
	always @(posedge clk)
	begin
		if (mem_rd_n && mem_wr_n)
		begin
			cnt           <= 0;
			early_grant_n <= 1'b0;
			data_valid_n  <= 1'b1;
		end
		else
		begin
			cnt           <= cnt + 1;
			early_grant_n <= (cnt < (slow ? 12 : 5));
			data_valid_n  <= (cnt < (slow ? 15 : 8));
		end
	end
endmodule
`default_nettype wire

// ### test/test_board_bus_decode_glue.sv
// test_board_bus_decode_glue: self-checking bench of the glue block
// assumes bdg_pkg, bdg_top and bdg_dram_model compiled first
`timescale 1ns/1ps
`default_nettype none
module test_board_bus_decode_glue;
	import bdg_pkg::*;
	localparam int         DLY  = 2;
	localparam logic [4:0] IDLE = 5'h1F;
	localparam logic [4:0] PRD  = 5'h15;
	localparam logic [4:0] PWR  = 5'h16;
	localparam logic [4:0] MRD  = 5'h19;
	localparam logic [4:0] MWR  = 5'h1A;
	localparam logic [4:0] INTA = 5'h07;
	logic        clk, arst_n, gnt_n, hold, strap, slow, smem_in;
	logic        oe, pr_n, pw_n, mr_n, mw_n, inward, rom_n, ram_n;
	logic        wait_n, ready, offb, egn, dvn;
	logic [4:0]  ctl;
	logic [3:0]  dstb, chg_n, mod;
	logic [7:0]  cpu_addr_hi, bus_addr_lo, dma_addr_hi, din, dout;
	logic [7:0]  addr_hi, smem_ctrl, a, d;
	logic [15:0] sel_n;
	logic [31:0] seed;
	int          error_cnt, cmp_count, map, n, g, i, k;
	logic [7:0]  mports[$] = '{8'h1A, 8'h19, 8'h18, 8'h1B};
	int          mval[$]   = '{1, 2, 0, 2};

	bdg_top #(.WAIT_DELAY(DLY)) i_bdg_top (
		.clk(clk), .arst_n(arst_n), .cpu_addr_hi(cpu_addr_hi),
		.bus_addr_lo(bus_addr_lo), .cpu_m1_n(ctl[4]),
		.cpu_iorq_n(ctl[3]), .cpu_mreq_n(ctl[2]), .cpu_rd_n(ctl[1]),
		.cpu_wr_n(ctl[0]), .bus_grant_from_cpu_n(gnt_n),
		.dma_owns_bus(hold), .dma_addr_hi(dma_addr_hi),
		.dma_port_read_n(dstb[3]), .dma_port_write_n(dstb[2]),
		.dma_mem_read_n(dstb[1]), .dma_mem_write_n(dstb[0]),
		.dma_channel_grant_n(chg_n), .ext_vector_strap(strap),
		.dram_early_grant_n(egn), .dram_data_valid_n(dvn),
		.modem_ring_n(mod[1:0]), .modem_ready_n(mod[3:2]),
		.smem_data_in(smem_in), .internal_data_lines_in(din),
		.internal_data_lines_out(dout), .internal_data_lines_oe(oe),
		.addr_hi(addr_hi), .port_read_strobe_n(pr_n),
		.port_write_strobe_n(pw_n), .mem_read_strobe_n(mr_n),
		.mem_write_strobe_n(mw_n), .data_buf_inward(inward),
		.rom_cs_n(rom_n), .ram_cs_n(ram_n), .cpu_wait_n(wait_n),
		.dma_ready(ready), .io_block_sel_n(sel_n),
		.offboard_port_flag(offb), .smem_ctrl(smem_ctrl)
	);
	bdg_dram_model i_bdg_dram_model (
		.clk(clk), .mem_rd_n(mr_n), .mem_wr_n(mw_n), .slow(slow),
		.early_grant_n(egn), .data_valid_n(dvn)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// compare tasks and reference model
	// ----------------------------------------
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_sel(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic is_ext(input logic [7:0] p);
		return !(p[7:3] == 5'h01 || p[7:3] == 5'h03 || p[7:2] == 6'h0A
			|| p[7:3] == 5'h06 || p[7:4] == 4'hF);
	endfunction
	function automatic logic exp_rom(input int m, input logic [4:0] t);
		return (m == 0 && t < ROM56_TOP) || (m == 1 && t < ROM16_TOP);
	endfunction
	function automatic logic [15:0] exp_sel(input logic [7:0] p);
		return (p < 8'h40) ? ~(16'h0001 << p[5:2]) : 16'hFFFF;
	endfunction

	// ----------------------------------------
	// bus drivers
	// ----------------------------------------
	task automatic cyc(input logic [4:0] c, input logic [7:0] hi,
		input logic [7:0] lo, input logic [7:0] dat);
		@(posedge clk);
		ctl         <= c;
		cpu_addr_hi <= hi;
		bus_addr_lo <= lo;
		din         <= dat;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic settle(output int c);
		c = 0;
		while (wait_n !== 1'b1 && c < 60)
		begin
			@(posedge clk);
			#1;
			c++;
		end
		chk_bit(c < 60, 1'b1);
		cyc(IDLE, 8'h00, 8'h00, 8'h00);
	endtask
	task automatic dcyc(input logic [3:0] s);
		@(posedge clk);
		dstb <= s;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task finish_test;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		seed        = 32'hA93FCB08;
		arst_n      = 1'b0;
		ctl         = IDLE;
		{gnt_n, hold, strap, slow, smem_in} = 5'h10;
		dstb        = 4'hF;
		chg_n       = 4'hF;
		mod         = 4'h0;
		{cpu_addr_hi, bus_addr_lo, dma_addr_hi, din} = 32'h0;
		error_cnt   = 0;
		cmp_count   = 0;
		map         = 0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk_byte(smem_ctrl, SMEM_RESET);
		chk_bit(inward, 1'b0);
		cyc(MWR, 8'h00, PORT_MAP_OFF_A, 8'h00);
		chk_bit(ram_n, 1'b0);
		chk_bit(rom_n, 1'b1);
		chk_bit(mw_n, 1'b0);
		settle(n);
		for (k = 0; k < 5; k++)
		begin
			if (k > 0)
			begin
				cyc(PWR, 8'h00, mports[k-1], 8'($random(seed)));
				map = mval[k-1];
			end
			for (i = 0; i < 32; i++)
			begin
				cyc(MRD, 8'(i << 3), 8'h00, 8'h00);
				chk_bit(rom_n, !exp_rom(map, 5'(i)));
				chk_bit(ram_n, exp_rom(map, 5'(i)));
				chk_byte(addr_hi, 8'(i << 3));
				chk_bit(mr_n, 1'b0);
				settle(n);
			end
		end
		for (k = 0; k < 2; k++)
		begin
			@(posedge clk);
			slow <= (k == 1);
			g = (k == 1 ? 13 : 6) + DLY;
			cyc(MRD, 8'hE0, 8'h00, 8'h00);
			chk_bit(wait_n, 1'b0);
			settle(n);
			chk_bit(n + 2 >= g && n + 2 <= g + 7, 1'b1);
		end
		for (i = 0; i < 48; i++)
		begin
			a = 8'($random(seed));
			if (i < 32)
				a[7:6] = 2'b00;
			if (i == 47)
				a[7:4] = 4'hF;
			cyc(PRD, 8'h00, a, 8'h00);
			chk_sel(sel_n, exp_sel(a));
			chk_bit(offb, is_ext(a));
			chk_bit(inward, is_ext(a));
			chk_bit(pr_n, 1'b0);
		end
		for (k = 0; k < 2; k++)
		begin
			@(posedge clk);
			strap <= (k == 1);
			cyc(INTA, 8'h00, 8'h00, 8'h00);
			chk_bit(inward, k == 1);
		end
		for (k = 0; k < 4; k++)
		begin
			d = 8'($random(seed));
			@(posedge clk);
			mod <= d[3:0];
			smem_in <= d[0];
			cyc(PWR, 8'h00, PORT_SMEM + 8'(k), d);
			chk_byte(smem_ctrl, d);
			chk_bit(pw_n, 1'b0);
			cyc(PRD, 8'h00, PORT_SMEM + 8'(k), 8'h00);
			chk_byte(dout, {d[0], d[6:0]});
			chk_bit(oe, 1'b1);
			cyc(PRD, 8'h00, PORT_MODEM, 8'h00);
			chk_byte(dout, {4'h0, d[3:0]});
		end
		cyc(PWR, 8'h00, PORT_MAP_ROM56, 8'h00);
		cyc(IDLE, 8'h00, PORT_MAP_ROM56, 8'h00);
		@(posedge clk);
		hold <= 1'b1;
		gnt_n <= 1'b0;
		dma_addr_hi <= 8'hA5;
		for (i = 0; i < 8; i++)
		begin
			dcyc({i[2], i[1], 1'b1, i[0]});
			chk_byte(addr_hi, 8'hA5);
			chk_bit(pr_n, i[2]);
			chk_bit(pw_n, i[1]);
			chk_bit(mw_n, i[0]);
			chk_sel(sel_n, 16'hFFFF);
		end
		dcyc(4'hD);
		chk_bit(ram_n, 1'b0);
		chk_bit(mr_n, 1'b0);
		chk_bit(ready, 1'b0);
		dcyc(4'h9);
		chk_bit(pw_n, 1'b1);
		n = 0;
		while (ready !== 1'b1 && n < 60)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk_bit(n < 60, 1'b1);
		chk_bit(pw_n, 1'b0);
		for (k = 0; k < 4; k++)
		begin
			@(posedge clk);
			chg_n <= ~(4'h1 << k);
			dcyc(4'h7);
			chk_bit(inward, k != 2);
		end
		finish_test;
	end

	initial
	begin
		#300000;
		error_cnt++;
		finish_test;
	end
endmodule
`default_nettype wire
